//--- design/ats_taskfile.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Write fault sets status write fault flag
// R2 - Seek complete flag shows card ready
// R3 - Data request set on transfer need, next command clears
// R4 - Corrected error flag set, read continues
// R5 - Index flag always reads zero
// R6 - Error flag from failed command, next command clears
// R7 - Failing sector address left in address registers
// R8 - Device control accepted even while busy
// R9 - Soft reset held clears status, loads diagnostic
// R10 - Host writes zero to device control upper bits
// R11 - Interrupt disable bit gates request, zero at power-on
// R12 - Drive address bit 6 low during writes
// R13 - Drive address bits 5..2 inverted head bits
// R14 - Drive select bits low for active selected drive
// R15 - Host loads parameters, writes command when idle
// R16 - Class 1 raises busy within 400 ns
// R17 - Class 2: busy, data request in 700 us
// R18 - Class 3: busy, data request in 20 ms
// R19 - Decoder recognises listed codes and classes
// R20 - Power check in standby loads 00h, interrupts
// R21 - Power check while idle loads FFh, interrupts
// R22 - Drive-only commands ignore head bits
// R23 - Status read clears interrupt, alternate does not
// R24 - While busy task file writes blocked, bits invalid
// R25 - Busy shown during soft reset and recovery
module ats_taskfile
	import ats_pkg::*;
#(
	parameter int unsigned P_DRQ2_CYC = DRQ2_CYC,
	parameter int unsigned P_DRQ3_CYC = DRQ3_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata_q,
	output logic interrupt_request_out,
	output logic cmd_start_q,
	output logic [7:0] cmd_code_q,
	output ats_class_t cmd_class_q,
	output logic cmd_drive_q,
	output logic [3:0] cmd_head_q,
	output logic cmd_lba_q,
	output logic [7:0] tf_feature_q,
	output logic [7:0] tf_sec_cnt_q,
	output logic [7:0] tf_sec_num_q,
	output logic [7:0] tf_cyl_lo_q,
	output logic [7:0] tf_cyl_hi_q,
	input wire logic be_drq,
	input wire logic be_done,
	input wire logic be_err,
	input wire logic [7:0] be_err_code,
	input wire logic [27:0] be_fail_lba,
	input wire logic be_write_fault,
	input wire logic be_corrected,
	input wire logic be_write_active,
	input wire logic pwr_standby,
	input wire logic card_drive_num
);

	localparam int BSY_RISE_LIM = BSY_RISE_CYC;

	ats_tf_t s_q; // Registered state
	ats_tf_t s_d; // Next state
	logic busy; // Busy flag as reported
	logic rdy; // Card able to take commands
	logic [7:0] stat; // Status byte
	logic [7:0] drv_addr; // Drive address readback byte
	logic done_ev; // Back end ends the command
	logic cmd_acc; // Command write taken
	logic set_ev; // Interrupt source this cycle
	logic tmr_load; // Start deadline timer
	logic tmr_stop; // Cancel deadline timer
	logic [TMR_W-1:0] tmr_val; // Deadline in cycles
	logic tmr_exp; // Deadline reached
	logic dec_known; // Code is in the command set
	ats_class_t dec_cls; // Acceptance class
	logic dec_head_full; // Drive and head both used
	logic dec_cpm; // Power mode check
	logic dec_nop; // Finished as no-operation

	// Command decoder
	ats_cmd_decode u_dec (
		.code(s_q.command),
		.known(dec_known),
		.cls(dec_cls),
		.head_full(dec_head_full),
		.cpm(dec_cpm),
		.nop(dec_nop)
	);

	// Deadline for data request and reset recovery
	ats_timer u_tmr (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(tmr_load),
		.stop(tmr_stop),
		.load_val(tmr_val),
		.expired(tmr_exp)
	);

	// Next state of the whole front end
	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		tmr_load = 1'b0;
		tmr_stop = 1'b0;
		tmr_val = '0;
		set_ev = 1'b0;
		busy = (s_q.st != ST_READY); // R25
		rdy = (s_q.st != ST_SRST) && (s_q.st != ST_RECOVER);
		// Status byte; only busy is meaningful while busy
		stat = 8'h00;
		stat[ST_BSY] = busy;
		if (!busy) begin // R24
			stat[ST_RDY] = rdy;
			stat[ST_DWF] = s_q.wf; // R1
			stat[ST_DSC] = rdy; // R2
			stat[ST_DRQ] = s_q.data_request_flag; // R3
			stat[ST_CORRECTED_ERROR_FLAG] = s_q.corrected_error_flag; // R4
			stat[ST_IDX] = 1'b0; // R5
			stat[ST_ERR] = s_q.err; // R6
		end
		// Drive address readback, bit 7 reads zero
		drv_addr = 8'h00;
		drv_addr[DA_WTG] = !be_write_active; // R12
		drv_addr[DA_HS_HI:DA_HS_LO] = ~s_q.drv_head[DH_HS_HI:DH_HS_LO]; // R13
		drv_addr[DA_DS1_N] = !(rdy && s_q.drv_head[DH_DRV] && card_drive_num); // R14
		drv_addr[DA_DS0_N] = !(rdy && !s_q.drv_head[DH_DRV] && !card_drive_num); // R14
		done_ev = be_done && ((s_q.st == ST_EXEC) || ((s_q.st == ST_READY) && s_q.data_request_flag));
		cmd_acc = host_wr && (host_addr == OFS_STAT_CMD) && !busy && !s_q.srst; // R15

		// Host reads
		if (host_rd) begin
			case (host_addr)
				OFS_ERR_FEAT, OFS_ERR_ALT: s_d.rdata = s_q.error;
				OFS_SEC_CNT: s_d.rdata = s_q.sec_cnt;
				OFS_SEC_NUM: s_d.rdata = s_q.sec_num;
				OFS_CYL_LO: s_d.rdata = s_q.cyl_lo;
				OFS_CYL_HI: s_d.rdata = s_q.cyl_hi;
				OFS_DRV_HEAD: s_d.rdata = s_q.drv_head;
				OFS_STAT_CMD: begin
					s_d.rdata = stat;
					s_d.pend = 1'b0; // R23
				end
				OFS_ALT_DEVCTL: s_d.rdata = stat; // R23
				OFS_DRV_ADDR: s_d.rdata = drv_addr;
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Command sequencing
		unique case (s_q.st)
			ST_SRST: begin
				// Leave reset once the host drops the bit
				if (!s_q.srst) begin
					s_d.st = ST_RECOVER; // R9
					tmr_load = 1'b1;
					tmr_val = TMR_W'(RECOVER_CYC);
				end
			end
			ST_RECOVER: begin
				if (tmr_exp) begin
					s_d.st = ST_READY;
					s_d.error = DIAG_OK; // R9
				end
			end
			ST_READY: begin
				s_d.st = ST_READY;
			end
			ST_DISPATCH: begin
				s_d.cls = dec_cls;
				s_d.drive = s_q.drv_head[DH_DRV];
				s_d.head = dec_head_full ? s_q.drv_head[DH_HS_HI:DH_HS_LO] : 4'h0; // R22
				s_d.lba = s_q.drv_head[DH_LBA];
				if (!dec_known) begin
					// Unknown code is aborted
					s_d.st = ST_READY;
					s_d.err = 1'b1; // R6
					s_d.error = ERR_ABORT;
					set_ev = 1'b1;
				end else if (dec_cpm) begin
					s_d.st = ST_READY;
					s_d.sec_cnt = pwr_standby ? CPM_STANDBY : CPM_IDLE; // R20 R21
					set_ev = 1'b1; // R20 R21
				end else if (dec_nop) begin
					s_d.st = ST_READY; // R19
					set_ev = 1'b1;
				end else begin
					// Hand the command to the back end
					s_d.start = 1'b1;
					s_d.st = ST_EXEC;
					if (dec_cls != CLS_1) begin
						tmr_load = 1'b1;
						tmr_val = (dec_cls == CLS_2) ? TMR_W'(P_DRQ2_CYC) : TMR_W'(P_DRQ3_CYC); // R17 R18
					end
				end
			end
			ST_EXEC: begin
				if (be_drq) begin
					// Data request and busy drop in the same cycle
					s_d.data_request_flag = 1'b1; // R3 R17 R18
					s_d.st = ST_READY; // R17 R18
					tmr_stop = 1'b1;
				end else if (tmr_exp) begin
					// Buffer never became ready in time
					s_d.st = ST_READY;
					s_d.err = 1'b1;
					s_d.error = ERR_ABORT;
					set_ev = 1'b1;
				end
			end
		endcase

		// Command completion by the back end
		if (done_ev) begin
			s_d.st = ST_READY;
			s_d.data_request_flag = 1'b0;
			tmr_stop = 1'b1;
			s_d.err = be_err; // R6
			set_ev = 1'b1;
			if (be_err) begin
				s_d.error = be_err_code;
				s_d.sec_num = be_fail_lba[7:0]; // R7
				s_d.cyl_lo = be_fail_lba[15:8]; // R7
				s_d.cyl_hi = be_fail_lba[23:16]; // R7
				s_d.drv_head[DH_HS_HI:DH_HS_LO] = be_fail_lba[27:24]; // R7
			end
		end

		// Host writes
		if (host_wr) begin
			if (host_addr == OFS_ALT_DEVCTL) begin
				// Taken even while busy; other bits ignored
				s_d.srst = host_wdata[DC_SRST]; // R8 R10
				s_d.ien_n = host_wdata[DC_IEN]; // R8 R11
			end else if (!busy) begin // R24
				case (host_addr)
					OFS_ERR_FEAT, OFS_ERR_ALT: s_d.feature = host_wdata;
					OFS_SEC_CNT: s_d.sec_cnt = host_wdata;
					OFS_SEC_NUM: s_d.sec_num = host_wdata;
					OFS_CYL_LO: s_d.cyl_lo = host_wdata;
					OFS_CYL_HI: s_d.cyl_hi = host_wdata;
					OFS_DRV_HEAD: s_d.drv_head = host_wdata;
					OFS_STAT_CMD: begin
						if (cmd_acc) begin
							s_d.command = host_wdata;
							s_d.st = ST_DISPATCH; // R16
							s_d.data_request_flag = 1'b0; // R3
							s_d.err = 1'b0; // R6
							s_d.corrected_error_flag = 1'b0;
							s_d.wf = 1'b0;
						end
					end
					default: s_d.wf = s_d.wf;
				endcase
			end
		end

		// Sticky events win over the command clear
		if (rdy && be_write_fault) begin
			s_d.wf = 1'b1; // R1
		end
		if (rdy && be_corrected) begin
			s_d.corrected_error_flag = 1'b1; // R4
		end
		if (set_ev) begin
			s_d.pend = 1'b1; // R20 R21
		end

		// Soft reset held: clear status, stay busy
		if (s_q.srst) begin
			s_d.st = ST_SRST; // R9 R25
			s_d.data_request_flag = 1'b0;
			s_d.err = 1'b0;
			s_d.corrected_error_flag = 1'b0;
			s_d.wf = 1'b0;
			s_d.pend = 1'b0;
			tmr_stop = 1'b1;
		end

		s_d.irq = s_d.pend && !s_d.ien_n; // R11
	end

	// State register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= TF_RST; // R11
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign host_rdata_q = s_q.rdata;
	assign interrupt_request_out = s_q.irq;
	assign cmd_start_q = s_q.start;
	assign cmd_code_q = s_q.command;
	assign cmd_class_q = s_q.cls;
	assign cmd_drive_q = s_q.drive;
	assign cmd_head_q = s_q.head;
	assign cmd_lba_q = s_q.lba;
	assign tf_feature_q = s_q.feature;
	assign tf_sec_cnt_q = s_q.sec_cnt;
	assign tf_sec_num_q = s_q.sec_num;
	assign tf_cyl_lo_q = s_q.cyl_lo;
	assign tf_cyl_hi_q = s_q.cyl_hi;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	busy_rise_a: assert property (cmd_acc |-> ##[1:BSY_RISE_LIM] (s_q.st != ST_READY)) // R16
		else $error("busy not raised after command write");
	flags_clear_a: assert property (cmd_acc |=> !s_q.data_request_flag && !s_q.err) // R3
		else $error("data request or error survived a new command");
	drq_drop_a: assert property ($rose(s_q.data_request_flag) |-> (s_q.st == ST_READY) && !s_q.err) // R17
		else $error("busy still set when data request rose");
	idx_zero_a: assert property ($past(host_rd) && ($past(host_addr) == OFS_STAT_CMD ||
		$past(host_addr) == OFS_ALT_DEVCTL) |-> !host_rdata_q[ST_IDX]) // R5
		else $error("index bit read as one");
	devctl_wr_a: assert property (host_wr && host_addr == OFS_ALT_DEVCTL |=>
		s_q.srst == $past(host_wdata[DC_SRST]) && s_q.ien_n == $past(host_wdata[DC_IEN])) // R8
		else $error("device control write lost");
	srst_hold_a: assert property (s_q.srst |=> s_q.st == ST_SRST && !s_q.err && !s_q.data_request_flag
		&& !s_q.wf) // R9
		else $error("soft reset did not hold the card busy and clear");
	cpm_idle_a: assert property (s_q.st == ST_DISPATCH && dec_cpm && !pwr_standby
		&& !s_q.srst |=> s_q.sec_cnt == CPM_IDLE && s_q.pend && s_q.st == ST_READY) // R21
		else $error("idle power check did not load FFh");
	cpm_stby_a: assert property (s_q.st == ST_DISPATCH && dec_cpm && pwr_standby
		&& !s_q.srst |=> s_q.sec_cnt == CPM_STANDBY && s_q.pend) // R20
		else $error("standby power check did not load 00h");
	drv_addr_a: assert property (host_rd && host_addr == OFS_DRV_ADDR |=>
		host_rdata_q[DA_HS_HI:DA_HS_LO] == ~$past(s_q.drv_head[DH_HS_HI:DH_HS_LO])
		&& host_rdata_q[DA_WTG] == !$past(be_write_active)) // R13
		else $error("drive address readback wrong");
	irq_ack_a: assert property (host_rd && host_addr == OFS_STAT_CMD && !set_ev |=>
		!s_q.pend && !interrupt_request_out) // R23
		else $error("status read did not clear interrupt");
	alt_keep_a: assert property (s_q.pend && host_rd && host_addr == OFS_ALT_DEVCTL
		&& !s_q.srst |=> s_q.pend) // R23
		else $error("alternate status read cleared interrupt");
	ien_gate_a: assert property (interrupt_request_out == (s_q.pend && !s_q.ien_n)) // R11
		else $error("interrupt output not gated by disable bit");
	fail_addr_a: assert property (done_ev && be_err && !s_q.srst && !host_wr |=>
		{s_q.drv_head[DH_HS_HI:DH_HS_LO], s_q.cyl_hi, s_q.cyl_lo, s_q.sec_num}
		== $past(be_fail_lba)) // R7
		else $error("failing sector address not kept");
	head_mask_a: assert property (s_q.st == ST_DISPATCH && !dec_head_full |=>
		cmd_head_q == 4'h0) // R22
		else $error("head bits passed for drive-only command");

	cls2_drq_c: cover property (s_q.st == ST_EXEC && s_q.cls == CLS_2 && be_drq);
	cpm_c: cover property (s_q.st == ST_DISPATCH && dec_cpm);
	srst_c: cover property (s_q.st == ST_RECOVER ##1 s_q.st == ST_READY);
	err_done_c: cover property (done_ev && be_err);

endmodule // ats_taskfile

//--- design/ats_pkg.sv
package ats_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int BSY_RISE_NS = 400;
	localparam int BSY_RISE_CYC = BSY_RISE_NS / CLK_PERIOD_NS;
	localparam int DRQ2_US = 700;
	localparam int DRQ2_CYC = DRQ2_US * 1000 / CLK_PERIOD_NS;
	localparam int DRQ3_MS = 20;
	localparam int DRQ3_CYC = DRQ3_MS * 1000 * 1000 / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = 4;
	localparam int TMR_W = 20;

	// Task file offsets
	localparam logic [3:0] OFS_ERR_FEAT = 4'h1;
	localparam logic [3:0] OFS_SEC_CNT = 4'h2;
	localparam logic [3:0] OFS_SEC_NUM = 4'h3;
	localparam logic [3:0] OFS_CYL_LO = 4'h4;
	localparam logic [3:0] OFS_CYL_HI = 4'h5;
	localparam logic [3:0] OFS_DRV_HEAD = 4'h6;
	localparam logic [3:0] OFS_STAT_CMD = 4'h7;
	localparam logic [3:0] OFS_ERR_ALT = 4'hD;
	localparam logic [3:0] OFS_ALT_DEVCTL = 4'hE;
	localparam logic [3:0] OFS_DRV_ADDR = 4'hF;

	// Status bit positions
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DWF = 5;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_CORRECTED_ERROR_FLAG = 2;
	localparam int ST_IDX = 1;
	localparam int ST_ERR = 0;

	// Device control, drive/head and drive address fields
	localparam int DC_SRST = 2;
	localparam int DC_IEN = 1;
	localparam int DH_LBA = 6;
	localparam int DH_DRV = 4;
	localparam int DH_HS_HI = 3;
	localparam int DH_HS_LO = 0;
	localparam int DA_WTG = 6;
	localparam int DA_HS_HI = 5;
	localparam int DA_HS_LO = 2;
	localparam int DA_DS1_N = 1;
	localparam int DA_DS0_N = 0;

	// Values loaded by hardware
	localparam logic [7:0] SEC_CNT_RST = 8'h01;
	localparam logic [7:0] DH_RST = 8'hA0;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] CPM_STANDBY = 8'h00;
	localparam logic [7:0] CPM_IDLE = 8'hFF;

	// Command codes decoded inside the block; seek codes still go to the back end
	localparam logic [7:0] CPM_CODE_A = 8'h98;
	localparam logic [7:0] CPM_CODE_B = 8'hE5;
	localparam logic [7:0] NOP_CODE = 8'h00;
	localparam logic [3:0] RECAL_HI = 4'h1;
	localparam logic [3:0] SEEK_HI = 4'h7;

	typedef enum logic [1:0] {CLS_1, CLS_2, CLS_3} ats_class_t;
	typedef enum logic [2:0] {ST_SRST, ST_RECOVER, ST_READY, ST_DISPATCH, ST_EXEC} ats_state_t;

	// Command table entry: code, acceptance class, drive and head both used
	typedef struct packed {
		logic [7:0] code;
		ats_class_t cls;
		logic head_full;
	} ats_cmd_ent_t;

	localparam int CMD_N = 33;
	localparam ats_cmd_ent_t CMD_TABLE [CMD_N] = '{
		'{8'h90, CLS_1, 1'b0}, '{8'hC0, CLS_1, 1'b1}, '{8'hEC, CLS_1, 1'b0}, '{8'hE3, CLS_1, 1'b0},
		'{8'h97, CLS_1, 1'b0}, '{8'hE1, CLS_1, 1'b0}, '{8'h95, CLS_1, 1'b0}, '{8'h91, CLS_1, 1'b1},
		'{8'hE4, CLS_1, 1'b0}, '{8'hC8, CLS_1, 1'b1}, '{8'hC4, CLS_1, 1'b1}, '{8'h20, CLS_1, 1'b1},
		'{8'h21, CLS_1, 1'b1}, '{8'h40, CLS_1, 1'b1}, '{8'h41, CLS_1, 1'b1}, '{8'h03, CLS_1, 1'b0},
		'{8'hEF, CLS_1, 1'b0}, '{8'hC6, CLS_1, 1'b0}, '{8'hE6, CLS_1, 1'b0}, '{8'h99, CLS_1, 1'b0},
		'{8'hE2, CLS_1, 1'b0}, '{8'h96, CLS_1, 1'b0}, '{8'hE0, CLS_1, 1'b0}, '{8'h94, CLS_1, 1'b0},
		'{8'h87, CLS_1, 1'b1}, '{8'hF5, CLS_1, 1'b1}, '{8'hE8, CLS_2, 1'b0}, '{8'hCA, CLS_2, 1'b1},
		'{8'h30, CLS_2, 1'b1}, '{8'h31, CLS_2, 1'b1}, '{8'h38, CLS_2, 1'b1}, '{8'hC5, CLS_3, 1'b1},
		'{8'hCD, CLS_3, 1'b1}
	};
	localparam int CMD_3C_IDX = 0;
	localparam logic [7:0] WRITE_VERIFY_CODE = 8'h3C;

	// Whole state of the task file front end
	typedef struct packed {
		ats_state_t st;
		logic [7:0] feature;
		logic [7:0] sec_cnt;
		logic [7:0] sec_num;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] drv_head;
		logic [7:0] command;
		logic [7:0] error;
		logic [7:0] rdata;
		logic srst;
		logic ien_n;
		logic data_request_flag;
		logic err;
		logic corrected_error_flag;
		logic wf;
		logic pend;
		logic irq;
		logic start;
		ats_class_t cls;
		logic drive;
		logic [3:0] head;
		logic lba;
	} ats_tf_t;

	localparam ats_tf_t TF_RST = '{st: ST_SRST, sec_cnt: SEC_CNT_RST, drv_head: DH_RST,
		cls: CLS_1, default: '0};

endpackage

//--- design/ats_cmd_decode.sv
`timescale 1ns/1ps
module ats_cmd_decode
	import ats_pkg::*;
(
	input wire logic [7:0] code,
	output logic known,
	output ats_class_t cls,
	output logic head_full,
	output logic cpm,
	output logic nop
);

	// Table lookup plus the codes with wildcard low nibbles
	always_comb begin
		known = 1'b0;
		cls = CLS_1;
		head_full = 1'b0;
		cpm = (code == CPM_CODE_A) || (code == CPM_CODE_B);
		nop = (code == NOP_CODE) || (code[7:4] == RECAL_HI);
		// Power check and no-operation codes are known; both finish inside the block
		if (cpm || nop) begin
			known = 1'b1; // R19
		end else if (code[7:4] == SEEK_HI) begin
			known = 1'b1; // R19
			head_full = 1'b1; // R22
		end else if (code == WRITE_VERIFY_CODE) begin
			known = 1'b1;
			cls = CLS_3; // R19
			head_full = 1'b1;
		end
		// Scan the listed codes
		for (int i = CMD_3C_IDX; i < CMD_N; i++) begin
			if (CMD_TABLE[i].code == code) begin
				known = 1'b1; // R19
				cls = CMD_TABLE[i].cls;
				head_full = CMD_TABLE[i].head_full; // R22
			end
		end
	end

endmodule // ats_cmd_decode

//--- design/ats_timer.sv
`timescale 1ns/1ps
module ats_timer
	import ats_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic stop,
	input wire logic [TMR_W-1:0] load_val,
	output logic expired
);

	// Down counter state
	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic run;
		logic exp;
	} ats_tmr_t;

	ats_tmr_t t_q;
	ats_tmr_t t_d;

	// Load, stop or count down; one pulse at the end
	always_comb begin
		t_d = t_q;
		t_d.exp = 1'b0;
		if (load) begin
			t_d.cnt = load_val;
			t_d.run = 1'b1;
		end else if (stop) begin
			t_d.run = 1'b0;
		end else if (t_q.run) begin
			if (t_q.cnt <= TMR_W'(1)) begin
				t_d.run = 1'b0;
				t_d.exp = 1'b1;
			end else begin
				t_d.cnt = t_q.cnt - TMR_W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign expired = t_q.exp;

	// Expiry only ends a running count
	tmr_expiry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(t_q.exp) |-> $past(t_q.run) && !$past(load) && !$past(stop))
		else $error("timer expired without a running count");

endmodule // ats_timer

//--- test/ats_host_model.sv
`timescale 1ns/1ps
// Host controller side of the task file, one access at a time
module ats_host_model
	import ats_pkg::*;
(
	input wire logic ref_clk,
	output logic [3:0] host_addr,
	output logic host_wr,
	output logic host_rd,
	output logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata_q
);
	// Idle bus at time zero
	initial begin
		host_addr = 4'h0;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 8'h00;
	end

	// One write, held until the taking edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		host_wr = 1'b0;
		// Released data no longer shows the last value
		host_wdata = ~d;
	endtask

	// One read, data registered at the taking edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		host_addr = a;
		host_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		host_rd = 1'b0;
		d = host_rdata_q;
	endtask

	// Device control write, unused bits always zero
	task automatic ctl(input logic srst, input logic ien_n);
		wr(OFS_ALT_DEVCTL, {5'h00, srst, ien_n, 1'b0});
	endtask

	// Command issue once busy reads clear, or after 50 polls
	task automatic cmd(input logic [7:0] c);
		logic [7:0] s;
		int n;
		s = 8'h80;
		n = 0;
		// Alternate status so a pending interrupt survives the poll
		while (s[ST_BSY] !== 1'b0 && n < 50) begin
			rd(OFS_ALT_DEVCTL, s);
			n++;
		end
		wr(OFS_STAT_CMD, c);
	endtask
endmodule // ats_host_model

//--- test/ats_taskfile_tb.sv
`timescale 1ns/1ps
module ats_taskfile_tb;
	import ats_pkg::*;
	localparam int unsigned DRQ2_T = 20; // Shortened class 2 deadline
	localparam int unsigned DRQ3_T = 40; // Shortened class 3 deadline
	localparam logic [7:0] STAT_READY = 8'h50; // Ready and seek complete
	// Command rows: code in, class and head use out
	localparam ats_cmd_ent_t ROWS [10] = '{'{8'h90, CLS_1, 1'b0}, '{8'hC0, CLS_1, 1'b1},
		'{8'h87, CLS_1, 1'b1}, '{8'hF5, CLS_1, 1'b1}, '{8'hE8, CLS_2, 1'b0},
		'{8'h30, CLS_2, 1'b1}, '{8'hC5, CLS_3, 1'b1}, '{8'hCD, CLS_3, 1'b1},
		'{8'h3C, CLS_3, 1'b1}, '{8'h7A, CLS_1, 1'b1}};
	localparam logic [7:0] FAIL_REGS [4] = '{8'h12, 8'h34, 8'h56, 8'hA3}; // Failing sector
	localparam logic [7:0] ABORTS [2] = '{8'hFF, 8'h30}; // Unknown code, class 2 timeout
	logic ref_clk, sys_rst, host_wr, host_rd, irq;
	logic [3:0] host_addr, seen_head, cmd_head_q;
	logic [7:0] host_wdata, host_rdata_q, tf_sec_cnt_q, v, cmd_code_q, seen_code;
	ats_class_t cmd_class_q, seen_cls;
	logic cmd_start_q, be_drq, be_done, be_err, be_write_fault, be_corrected;
	logic be_write_active, pwr_standby, card_drive_num;
	logic [7:0] be_err_code;
	logic [27:0] be_fail_lba;
	int mismatches = 0;
	int tests_run = 0;
	int starts = 0;
	int s0;

	ats_host_model i_ats_host_model (.ref_clk(ref_clk), .host_addr(host_addr),
		.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
		.host_rdata_q(host_rdata_q));
	ats_taskfile #(.P_DRQ2_CYC(DRQ2_T), .P_DRQ3_CYC(DRQ3_T)) i_ats_taskfile (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_q(host_rdata_q),
		.interrupt_request_out(irq), .cmd_start_q(cmd_start_q), .cmd_code_q(cmd_code_q),
		.cmd_class_q(cmd_class_q), .cmd_drive_q(), .cmd_head_q(cmd_head_q), .cmd_lba_q(),
		.tf_feature_q(), .tf_sec_cnt_q(tf_sec_cnt_q), .tf_sec_num_q(), .tf_cyl_lo_q(),
		.tf_cyl_hi_q(), .be_drq(be_drq), .be_done(be_done), .be_err(be_err),
		.be_err_code(be_err_code), .be_fail_lba(be_fail_lba),
		.be_write_fault(be_write_fault), .be_corrected(be_corrected),
		.be_write_active(be_write_active), .pwr_standby(pwr_standby),
		.card_drive_num(card_drive_num));

	// Free running 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Hang guard, well past the expected run
	initial begin
		#400000;
		mismatches++;
		complete_run();
	end

	// Captures each hand-over pulse with its class and head
	always @(posedge ref_clk) begin
		if (cmd_start_q === 1'b1) begin
			starts++;
			seen_cls = cmd_class_q;
			seen_code = cmd_code_q;
			seen_head = cmd_head_q;
		end
	end

	// Compare and count
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Bounded wait for the next hand-over pulse
	task automatic wait_start(input int base);
		int n;
		n = 0;
		while (starts == base && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		check("start", 8'(starts - base), 8'h01);
	endtask

	// Back end pulses
	task automatic data_request_flag();
		@(posedge ref_clk);
		#1 be_drq = 1'b1;
		@(posedge ref_clk);
		#1 be_drq = 1'b0;
	endtask
	task automatic done(input logic e);
		@(posedge ref_clk);
		#1 be_done = 1'b1;
		be_err = e;
		@(posedge ref_clk);
		#1 be_done = 1'b0;
		be_err = 1'b0;
	endtask

	// Status read through the alternate place
	task automatic alt(input string name, input logic [7:0] exp);
		i_ats_host_model.rd(OFS_ALT_DEVCTL, v);
		check(name, v, exp);
	endtask

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{be_drq, be_done, be_err, be_write_fault, be_corrected} = 5'h00;
		be_write_active = 1'b0;
		pwr_standby = 1'b0;
		card_drive_num = 1'b0;
		be_err_code = 8'h00;
		be_fail_lba = 28'h000_0000;
		repeat (12) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		alt("reset busy", 8'h80);
		repeat (10) @(posedge ref_clk);
		alt("ready", STAT_READY);
		i_ats_host_model.rd(OFS_ERR_FEAT, v);
		check("diag", v, DIAG_OK);
		i_ats_host_model.rd(OFS_DRV_ADDR, v);
		check("drv addr", v, 8'h7E);
		be_write_active = 1'b1;
		i_ats_host_model.rd(OFS_DRV_ADDR, v);
		check("drv addr wr", v, 8'h3E);
		be_write_active = 1'b0;
		i_ats_host_model.wr(OFS_DRV_HEAD, 8'hA5);
		i_ats_host_model.rd(OFS_DRV_ADDR, v);
		check("drv addr head", v, 8'h6A);
		// Card strapped as drive 1 with drive 1 selected
		card_drive_num = 1'b1;
		i_ats_host_model.wr(OFS_DRV_HEAD, 8'hB5);
		i_ats_host_model.rd(OFS_DRV_ADDR, v);
		check("drv1 sel", v, 8'h69);
		card_drive_num = 1'b0;
		i_ats_host_model.wr(OFS_DRV_HEAD, 8'hA5);
		// Ordinary commands from the rows
		foreach (ROWS[i]) begin
			s0 = starts;
			i_ats_host_model.cmd(ROWS[i].code);
			alt("busy", 8'h80);
			wait_start(s0);
			check("class", {6'h00, seen_cls}, {6'h00, ROWS[i].cls});
			check("code", seen_code, ROWS[i].code);
			check("head", {4'h0, seen_head}, ROWS[i].head_full ? 8'h05 : 8'h00);
			if (ROWS[i].cls != CLS_1) begin
				data_request_flag();
				alt("data req", 8'h58);
			end
			done(1'b0);
			alt("done", STAT_READY);
			check("irq set", {7'h00, irq}, 8'h01);
			i_ats_host_model.rd(OFS_STAT_CMD, v);
			@(posedge ref_clk);
			#1;
			check("irq clr", {7'h00, irq}, 8'h00);
		end
		// Power check, both codes in both modes
		for (int i = 0; i < 4; i++) begin
			pwr_standby = i[1];
			i_ats_host_model.cmd(i[0] ? CPM_CODE_A : CPM_CODE_B);
			repeat (3) @(posedge ref_clk);
			#1;
			check("pwr cnt", tf_sec_cnt_q, i[1] ? CPM_STANDBY : CPM_IDLE);
			check("pwr irq", {7'h00, irq}, 8'h01);
			i_ats_host_model.rd(OFS_STAT_CMD, v);
		end
		// Legacy no-operation ends inside the block
		s0 = starts;
		i_ats_host_model.cmd(8'h10);
		alt("nop stat", STAT_READY);
		check("nop start", 8'(starts - s0), 8'h00);
		i_ats_host_model.rd(OFS_STAT_CMD, v);
		// Interrupt masked, then let through
		i_ats_host_model.ctl(1'b0, 1'b1);
		i_ats_host_model.cmd(CPM_CODE_A);
		repeat (3) @(posedge ref_clk);
		#1;
		check("irq masked", {7'h00, irq}, 8'h00);
		i_ats_host_model.ctl(1'b0, 1'b0);
		@(posedge ref_clk);
		#1;
		check("irq unmasked", {7'h00, irq}, 8'h01);
		i_ats_host_model.rd(OFS_STAT_CMD, v);
		// Failed class 3 write leaves the failing sector behind
		s0 = starts;
		i_ats_host_model.cmd(8'hCD);
		wait_start(s0);
		be_err_code = 8'h10;
		be_fail_lba = 28'h356_3412;
		done(1'b1);
		alt("err stat", 8'h51);
		i_ats_host_model.rd(OFS_ERR_FEAT, v);
		check("err code", v, 8'h10);
		for (int k = 0; k < 4; k++) begin
			i_ats_host_model.rd(4'(OFS_SEC_NUM + k), v);
			check("fail addr", v, FAIL_REGS[k]);
		end
		// Sticky fault and corrected flags
		@(posedge ref_clk);
		#1 {be_write_fault, be_corrected} = 2'b11;
		@(posedge ref_clk);
		#1 {be_write_fault, be_corrected} = 2'b00;
		alt("fault corrected_error_flag", 8'h75);
		// Next command clears, busy refuses task file writes
		s0 = starts;
		i_ats_host_model.cmd(8'hC0);
		wait_start(s0);
		i_ats_host_model.wr(OFS_SEC_CNT, 8'h77);
		check("busy write", tf_sec_cnt_q, CPM_STANDBY);
		done(1'b0);
		alt("cleared", STAT_READY);
		// Soft reset taken while busy
		s0 = starts;
		i_ats_host_model.cmd(8'hC0);
		wait_start(s0);
		i_ats_host_model.ctl(1'b1, 1'b0);
		alt("srst busy", 8'h80);
		i_ats_host_model.ctl(1'b0, 1'b0);
		repeat (10) @(posedge ref_clk);
		alt("srst ready", STAT_READY);
		i_ats_host_model.rd(OFS_ERR_FEAT, v);
		check("srst diag", v, DIAG_OK);
		// Unknown code and class 2 without data request both abort
		foreach (ABORTS[k]) begin
			i_ats_host_model.cmd(ABORTS[k]);
			repeat (DRQ2_T + 10) @(posedge ref_clk);
			alt("abort stat", 8'h51);
			i_ats_host_model.rd(OFS_ERR_FEAT, v);
			check("abort code", v, ERR_ABORT);
		end
		complete_run();
	end
endmodule // ats_taskfile_tb
